//--- core/ipc_regs.vh
// Register map constants for the interrupt priority register bank
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word
`ifndef IPC_REGS_VH
`define IPC_REGS_VH
`define IPC_ADDR_W 4
`define IPC_OFS_CMP4 4'h0
`define IPC_OFS_ADCP 4'h4
`define IPC_OFS_LEVELS 4'h8
`define IPC_CMP4_LSB 0
`define IPC_ADCP0_LSB 4
`define IPC_ADCP1_LSB 8
`define IPC_ADCP2_LSB 12
`define IPC_LEVEL_RESET 3'h4
`define IPC_LEVEL_OFF 3'h0
`define IPC_CMP4_MASK 16'h0007
`define IPC_ADCP_MASK 16'h7770
`define IPC_RESP_OKAY 2'h0
`define IPC_RESP_SLVERR 2'h2
`endif

//--- core/ipc_level_field.v
// One 3-bit priority field with write strobe and power-on value
// Assumes the caller decodes the address and byte lanes
`timescale 1ns/100ps
`include "ipc_regs.vh"
module ipc_level_field (
	input wire aclk,
	input wire aresetn,
	input wire wr_en,
	input wire [2:0] wr_data,
	output reg [2:0] level,
	output wire enabled
);
	always @(posedge aclk) begin
		if (!aresetn) begin
			level <= `IPC_LEVEL_RESET;
		end else if (wr_en) begin
			level <= wr_data;
		end
	end
	// Code 000 blocks the source; 001..111 are levels 1..7 as-is
	assign enabled = (level != `IPC_LEVEL_OFF);
endmodule

//--- core/ipc_axil_resp.v
// Response holding stage for one AXI4-Lite answer channel
// Assumes the master keeps ready high until it sees valid
`timescale 1ns/100ps
module ipc_axil_resp (
	input wire aclk,
	input wire aresetn,
	input wire start,
	input wire ready,
	output reg valid
);
	always @(posedge aclk) begin
		if (!aresetn) begin
			valid <= 1'b0;
		end else if (start) begin
			valid <= 1'b1;
		end else if (ready) begin
			valid <= 1'b0;
		end
	end
endmodule

//--- core/ipc_priority_regs.v
// Interrupt priority register bank behind an AXI4-Lite slave
// Assumes one master, one write and one read in flight at most
//
// What this block does
// - Bits 15 to 3 of the comparator priority register read as zero and ignore writes.
// - The comparator 4 priority is a 3-bit read/write field at bits 2:0 resetting to 100.
// - Field code 111 means priority level 7, the highest.
// - Field code 001 means level 1, the lowest enabled, with codes between mapping linearly.
// - Field code 000 disables the source so it never requests.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
`include "ipc_regs.vh"
module ipc_priority_regs (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	output wire [2:0] comparator4_irq_level,
	output wire [2:0] adc_pair0_done_irq_level,
	output wire [2:0] adc_pair1_done_irq_level,
	output wire [2:0] adc_pair2_done_irq_level,
	output wire [3:0] source_enabled
);
	// One-hot write channel states
	localparam WS_IDLE = 4'h1;
	localparam WS_ADDR = 4'h2;
	localparam WS_DATA = 4'h4;
	localparam WS_WRITE = 4'h8;
	reg [3:0] wr_state;
	reg [3:0] next_wr_state;
	wire aw_take;
	wire w_take;
	wire aw_open;
	wire w_open;
	reg [`IPC_ADDR_W-1:0] aw_addr;
	reg aw_hit;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire do_write;
	wire do_read;
	wire wr_cmp4;
	wire wr_adcp;
	wire wr_pair0;
	wire wr_pair1;
	wire wr_pair2;
	wire rd_hit;
	wire [2:0] new_cmp4;
	wire [2:0] new_p0;
	wire [2:0] new_p1;
	wire [2:0] new_p2;
	wire [2:0] lvl_cmp4;
	wire [2:0] lvl_p0;
	wire [2:0] lvl_p1;
	wire [2:0] lvl_p2;
	reg [31:0] next_rdata;
	reg [1:0] next_rresp;

	// Word decode shared by both channels; upper address bits must be zero
	function addr_ok;
		input [31:0] a;
		begin
			addr_ok = (a[31:`IPC_ADDR_W] == 28'h000_0000) && (a[1:0] == 2'h0) &&
				((a[3:0] == `IPC_OFS_CMP4) || (a[3:0] == `IPC_OFS_ADCP) || (a[3:0] == `IPC_OFS_LEVELS));
		end
	endfunction

	// Same word test for the held write address and the status refusal
	function word_is;
		input [3:0] a;
		input [3:0] ofs;
		begin
			word_is = (a == ofs);
		end
	endfunction

	// Byte lane that carries a field whose low bit sits at lsb
	function lane_on;
		input [3:0] strb;
		input [31:0] lsb;
		begin
			lane_on = strb[lsb[4:3]];
		end
	endfunction

	// Three-bit field of a data word starting at lsb
	function [2:0] field_of;
		input [31:0] d;
		input [31:0] lsb;
		begin
			field_of = d[lsb +: 3];
		end
	endfunction

	// Read image of the comparator word: only bits 2:0 exist
	function [15:0] cmp4_image;
		input [2:0] lvl;
		begin
			cmp4_image = {13'h0000, lvl} & `IPC_CMP4_MASK;
		end
	endfunction

	// Read image of the pair word: gaps at 15, 11, 7 and 3:0 stay zero
	function [15:0] adcp_image;
		input [2:0] p2;
		input [2:0] p1;
		input [2:0] p0;
		begin
			adcp_image = {1'b0, p2, 1'b0, p1, 1'b0, p0, 4'h0} & `IPC_ADCP_MASK;
		end
	endfunction

	// Address and data latch separately so either may arrive first
	assign aw_open = (wr_state == WS_IDLE) || (wr_state == WS_DATA);
	assign w_open = (wr_state == WS_IDLE) || (wr_state == WS_ADDR);
	assign s_axi_awready = aw_open && !s_axi_bvalid;
	assign s_axi_wready = w_open && !s_axi_bvalid;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	// Holding both halves for a cycle keeps the field write off the bus path
	assign do_write = (wr_state == WS_WRITE) && !s_axi_bvalid;

	always @* begin
		next_wr_state = wr_state;
		case (wr_state)
			WS_IDLE: begin
				if (aw_take && w_take) begin
					next_wr_state = WS_WRITE;
				end else if (aw_take) begin
					next_wr_state = WS_ADDR;
				end else if (w_take) begin
					next_wr_state = WS_DATA;
				end
			end
			WS_ADDR: begin
				if (w_take) begin
					next_wr_state = WS_WRITE;
				end
			end
			WS_DATA: begin
				if (aw_take) begin
					next_wr_state = WS_WRITE;
				end
			end
			WS_WRITE: begin
				if (!s_axi_bvalid) begin
					next_wr_state = WS_IDLE;
				end
			end
			default: begin
				next_wr_state = WS_IDLE;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			wr_state <= WS_IDLE;
			aw_addr <= 4'h0;
			aw_hit <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bresp <= `IPC_RESP_OKAY;
		end else begin
			wr_state <= next_wr_state;
			if (aw_take) begin
				aw_addr <= s_axi_awaddr[`IPC_ADDR_W-1:0];
				aw_hit <= addr_ok(s_axi_awaddr);
			end
			if (w_take) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			// The status word is read-only, so a write to it is refused
			if (do_write) begin
				s_axi_bresp <= (aw_hit && !word_is(aw_addr, `IPC_OFS_LEVELS)) ? `IPC_RESP_OKAY : `IPC_RESP_SLVERR;
			end
		end
	end

	ipc_axil_resp u_bresp (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(do_write),
		.ready(s_axi_bready),
		.valid(s_axi_bvalid)
	);

	// Only the low byte lanes carry implemented bits; the rest are dropped
	assign wr_cmp4 = do_write && aw_hit && word_is(aw_addr, `IPC_OFS_CMP4) && lane_on(w_strb, `IPC_CMP4_LSB);
	assign wr_adcp = do_write && aw_hit && word_is(aw_addr, `IPC_OFS_ADCP);
	assign wr_pair0 = wr_adcp && lane_on(w_strb, `IPC_ADCP0_LSB);
	assign wr_pair1 = wr_adcp && lane_on(w_strb, `IPC_ADCP1_LSB);
	assign wr_pair2 = wr_adcp && lane_on(w_strb, `IPC_ADCP2_LSB);
	// Field values are cut from the held word so the instances need no slicing
	assign new_cmp4 = field_of(w_data, `IPC_CMP4_LSB);
	assign new_p0 = field_of(w_data, `IPC_ADCP0_LSB);
	assign new_p1 = field_of(w_data, `IPC_ADCP1_LSB);
	assign new_p2 = field_of(w_data, `IPC_ADCP2_LSB);

	ipc_level_field u_cmp4 (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(wr_cmp4),
		.wr_data(new_cmp4),
		.level(lvl_cmp4),
		.enabled(source_enabled[0])
	);

	ipc_level_field u_pair0 (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(wr_pair0),
		.wr_data(new_p0),
		.level(lvl_p0),
		.enabled(source_enabled[1])
	);

	ipc_level_field u_pair1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(wr_pair1),
		.wr_data(new_p1),
		.level(lvl_p1),
		.enabled(source_enabled[2])
	);

	ipc_level_field u_pair2 (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(wr_pair2),
		.wr_data(new_p2),
		.level(lvl_p2),
		.enabled(source_enabled[3])
	);

	// Field code is the level itself: 111 is 7, 001 is 1, 000 is off
	assign comparator4_irq_level = lvl_cmp4;
	assign adc_pair0_done_irq_level = lvl_p0;
	assign adc_pair1_done_irq_level = lvl_p1;
	assign adc_pair2_done_irq_level = lvl_p2;

	// Read side: one read in flight, answered the cycle after acceptance
	assign s_axi_arready = !s_axi_rvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign rd_hit = addr_ok(s_axi_araddr);

	always @* begin
		next_rdata = 32'h0000_0000;
		next_rresp = `IPC_RESP_OKAY;
		if (!rd_hit) begin
			next_rresp = `IPC_RESP_SLVERR;
		end else begin
			case (s_axi_araddr[`IPC_ADDR_W-1:0])
				`IPC_OFS_CMP4: begin
					next_rdata[15:0] = cmp4_image(lvl_cmp4);
				end
				`IPC_OFS_ADCP: begin
					next_rdata[15:0] = adcp_image(lvl_p2, lvl_p1, lvl_p0);
				end
				`IPC_OFS_LEVELS: begin
					next_rdata[3:0] = source_enabled;
				end
				default: begin
					next_rresp = `IPC_RESP_SLVERR;
				end
			endcase
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `IPC_RESP_OKAY;
		end else if (do_read) begin
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	ipc_axil_resp u_rresp (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(do_read),
		.ready(s_axi_rready),
		.valid(s_axi_rvalid)
	);
endmodule

//--- dv/ipc_priority_regs_assertions.sv
// Port assertions for the priority register bank
// Bound to ipc_priority_regs, one clock domain
`timescale 1ns/100ps
module ipc_chk (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_bvalid,
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire [2:0] comparator4_irq_level,
	input wire [2:0] adc_pair0_done_irq_level,
	input wire [2:0] adc_pair1_done_irq_level,
	input wire [2:0] adc_pair2_done_irq_level,
	input wire [3:0] source_enabled
);
	wire [2:0] c = comparator4_irq_level;
	wire [8:0] a = {adc_pair2_done_irq_level, adc_pair1_done_irq_level, adc_pair0_done_irq_level};
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rst;
		$rose(aresetn) |-> {a, c} == 12'h924;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset level");
	// Levels move only with a write answer, so stray updates show
	property p_c;
		$changed(c) |-> $rose(s_axi_bvalid);
	endproperty
	a_c: assert property (p_c) else $error("comparator level moved");
	property p_a;
		$changed(a) |-> $rose(s_axi_bvalid);
	endproperty
	a_a: assert property (p_a) else $error("pair level moved");
	property p_en;
		source_enabled == {|a[8:6], |a[5:3], |a[2:0], |c};
	endproperty
	a_en: assert property (p_en) else $error("bad enable");
	property p_max;
		c == 3'h7 |-> source_enabled[0];
	endproperty
	a_max: assert property (p_max) else $error("top level off");
	property p_min;
		a[2:0] == 3'h1 |-> source_enabled[1];
	endproperty
	a_min: assert property (p_min) else $error("low level off");
	// Reads take one cycle and block the next address until answered
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_rd_answer;
		s_axi_rvalid && !s_axi_arready;
	endsequence
	property p_rd;
		s_rd_take |=> s_rd_answer;
	endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	// A pending write answer closes both write channels
	property p_wr;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wr: assert property (p_wr) else $error("write channel open");
endmodule
bind ipc_priority_regs ipc_chk chk_u (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.comparator4_irq_level(comparator4_irq_level),
	.adc_pair0_done_irq_level(adc_pair0_done_irq_level),
	.adc_pair1_done_irq_level(adc_pair1_done_irq_level),
	.adc_pair2_done_irq_level(adc_pair2_done_irq_level),
	.source_enabled(source_enabled)
);

//--- dv/ipc_priority_regs_tb.sv
// Bench for the priority register bank
// Ready lines held high: stalls are left untested
`timescale 1ns/100ps
`include "ipc_regs.vh"
module ipc_priority_regs_tb;
	reg aclk = 0;
	reg aresetn = 0;
	reg awv = 0, wv = 0, arv = 0;
	reg [31:0] aw = 0, wd = 0, ar = 0, d, a;
	reg [3:0] ws = 0, sb;
	reg [15:0] m0, m4;
	reg [1:0] r;
	wire awr, wr, bv, arr, rv;
	wire [1:0] br, rr;
	wire [31:0] rd;
	wire [2:0] l0, l1, l2, l3;
	wire [3:0] en;
	integer num_errors = 0, checked = 0, seed = 38, i;
	ipc_priority_regs dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ar),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(1'b1), .comparator4_irq_level(l0), .adc_pair0_done_irq_level(l1),
		.adc_pair1_done_irq_level(l2), .adc_pair2_done_irq_level(l3), .source_enabled(en));
	initial forever #5 aclk = ~aclk;
	function [15:0] upd(input [15:0] o, input [31:0] v, input [15:0] k, input [3:0] s);
		reg [15:0] b;
		begin
			b = k & {{8{s[1]}}, {8{s[0]}}};
			upd = (o & ~b) | (v[15:0] & b);
		end
	endfunction
	task chk(input [39:0] n, input [31:0] e, input [31:0] s);
		begin
			checked = checked + 1;
			if (s !== e) begin
				num_errors = num_errors + 1;
				$display("CHECK FAILED %0s exp %h got %h", n, e, s);
			end
		end
	endtask
	task wrap_up;
		begin
			if (num_errors == 0 && checked > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task bus_wr(input [31:0] ad, input [31:0] v, input [3:0] s);
		begin
			aw <= ad;
			wd <= v;
			ws <= s;
			awv <= 1'b1;
			wv <= 1'b1;
			do begin
				@(posedge aclk);
				if (awr)
					awv <= 1'b0;
				if (wr)
					wv <= 1'b0;
			end while (!bv);
			r = br;
		end
	endtask
	task bus_rd(input [31:0] ad);
		begin
			ar <= ad;
			arv <= 1'b1;
			do begin
				@(posedge aclk);
				if (arr)
					arv <= 1'b0;
			end while (!rv);
			d = rd;
			r = rr;
		end
	endtask
	task reset_all;
		begin
			aresetn <= 1'b0;
			repeat (2) @(posedge aclk);
			aresetn <= 1'b1;
			m0 = 16'h0004;
			m4 = 16'h4440;
		end
	endtask
	task chk_all;
		begin
			bus_rd(`IPC_OFS_CMP4);
			chk("cmp", {16'h0, m0}, d);
			bus_rd(`IPC_OFS_ADCP);
			chk("adc", {16'h0, m4}, d);
			chk("lvl", {m4[14:12], m4[10:8], m4[6:4], m0[2:0]}, {l3, l2, l1, l0});
			chk("en", {|m4[14:12], |m4[10:8], |m4[6:4], |m0[2:0]}, en);
			bus_rd(`IPC_OFS_LEVELS);
			chk("rresp", `IPC_RESP_OKAY, r);
			chk("stat", {28'h000_0000, |m4[14:12], |m4[10:8], |m4[6:4], |m0[2:0]}, d);
		end
	endtask
	initial begin
		#60000;
		num_errors = num_errors + 1;
		wrap_up;
	end
	initial begin
		reset_all;
		chk_all;
		for (i = 0; i < 40; i = i + 1) begin
			d = $random(seed);
			sb = $random(seed);
			if (i >= 32) begin
				d = {16'h0, {4{1'b0, i[2:0]}}};
				sb = 4'hF;
			end
			a = d;
			bus_wr(`IPC_OFS_CMP4, a, sb);
			chk("bresp", `IPC_RESP_OKAY, r);
			m0 = upd(m0, a, `IPC_CMP4_MASK, sb);
			bus_wr(`IPC_OFS_ADCP, a, sb);
			chk("bresp", `IPC_RESP_OKAY, r);
			m4 = upd(m4, a, `IPC_ADCP_MASK, sb);
			chk_all;
		end
		for (i = 0; i < 3; i = i + 1) begin
			a = (i == 0) ? 32'h0000_0002 : (i == 1) ? 32'h0000_0008 : 32'h0000_000C;
			bus_wr(a, 32'hFFFF_FFFF, 4'hF);
			chk("bresp", `IPC_RESP_SLVERR, r);
			bus_rd(a);
			chk("rresp", (i == 1) ? `IPC_RESP_OKAY : `IPC_RESP_SLVERR, r);
		end
		chk_all;
		reset_all;
		chk_all;
		wrap_up;
	end
endmodule
